// *** include/led_strobe_params.svh ***
/*
 * Offsets, field positions, reset values and timing figures of the
 * strobe and PWM controller.
 * Assumes a 32-bit register port with byte addresses and a 25 MHz mclk.
 */
`ifndef LED_STROBE_PARAMS_SVH
`define LED_STROBE_PARAMS_SVH

// Register byte offsets
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_STROBE_DELAY  8'h08
`define REG_STROBE_DUR    8'h0C
`define REG_EXPO_DELAY    8'h10
`define REG_INTERVAL_LEN  8'h14
`define REG_INTERVAL_SEL  8'h18
`define REG_PWM_PERIOD    8'h1C
`define REG_DUTY_BASE     8'h20

// Control fields
`define CTRL_ENABLE_BIT   0
`define CTRL_POL_BIT      1
`define CTRL_LAST_LSB     4
`define CTRL_CHEN_LSB     8

// Reset values
`define CTRL_RST          32'h0000_0F00
`define WORD_RST          32'h0000_0000
`define INTERVAL_LEN_RST  32'h0000_FFFF

// Timing figures
`define TICK_NS           15
`define MCLK_NS           40
`define MIN_DUR_NS        1000
`define MAX_DUR_NS        1000000000
`define MAX_ON_NS         100000000

`endif

// *** include/led_strobe_pkg.sv ***
/*
 * Types shared by the strobe and PWM controller.
 * Assumes led_strobe_params.svh supplies the numeric constants.
 */
package led_strobe_pkg;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_RUN  = 2'b10
    } seq_state_t;

    typedef enum logic [2:0] {
        STB_IDLE  = 3'b001,
        STB_DELAY = 3'b010,
        STB_ON    = 3'b100
    } strobe_state_t;

    typedef logic [31:0] tick_t;
    typedef logic [3:0]  interval_t;

endpackage

// *** src/pwm_channel.sv ***
/*
 * One PWM intensity channel: compares the shared period count with its duty.
 * Assumes the period counter runs from zero to period minus one.
 */
`timescale 1ns/1ps
module pwm_channel
    import led_strobe_pkg::*;
(
    input  wire logic  mclk,
    input  wire logic  rst,
    input  wire logic  ce,
    input  wire logic  run,
    input  wire tick_t count,
    input  wire tick_t duty,
    output logic       pwm_out
);
    logic out_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            out_q <= 1'b0;
        end else if (ce) begin
            out_q <= run && (duty != 32'h0000_0000) && (count < duty);
        end
    end

    assign pwm_out = out_q;
endmodule

// *** src/led_strobe_pwm_control.sv ***
/*
 * Strobe, exposure and four-channel PWM controller run by a sixteen
 * interval sequencer, started from an external trigger edge.
 * Assumes a single 25 MHz mclk, a synchronous active-high reset, and
 * a trigger pin that is asynchronous to mclk.
 */
`timescale 1ns/1ps
`include "led_strobe_params.svh"

module led_strobe_pwm_control
    import led_strobe_pkg::*;
#(
    parameter int unsigned MAX_DUR_CYC = `MAX_DUR_NS / `MCLK_NS,
    parameter int unsigned MAX_ON_CYC  = `MAX_ON_NS / `MCLK_NS
)
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    input  wire logic        trigger_in,
    output logic             strobe_out,
    output logic             expose_start,
    output logic             seq_active,
    output logic [3:0]       pwm_out
);
    localparam int NUM_CH  = 4;
    localparam int NUM_INT = 16;
    localparam int unsigned MIN_DUR_CYC = (`MIN_DUR_NS + `MCLK_NS - 1) / `MCLK_NS;
    localparam tick_t MIN_DUR = tick_t'(MIN_DUR_CYC);
    localparam tick_t MAX_DUR = tick_t'(MAX_DUR_CYC);
    localparam tick_t MAX_ON  = tick_t'(MAX_ON_CYC);

    logic [31:0] ctrl_q;
    tick_t       strobe_delay_q;
    tick_t       strobe_dur_q;
    tick_t       expo_delay_q;
    tick_t       interval_len_q;
    interval_t   sel_q;
    tick_t       period_mem [NUM_INT];
    tick_t       duty_mem   [NUM_CH][NUM_INT];

    logic        trig_meta_q;
    logic        trig_sync_q;
    logic        trig_prev_q;
    logic        trig_edge;

    seq_state_t    seq_q;
    interval_t     interval_index;
    tick_t         ilen_cnt_q;
    logic          interval_start;
    logic          interval_end;
    interval_t     last_index;

    strobe_state_t stb_q;
    tick_t         stb_cnt_q;
    tick_t         dur_eff;
    logic          stb_active;
    logic          strobe_q;

    tick_t         expo_cnt_q;
    logic          expo_wait_q;
    logic          expo_pulse_q;

    tick_t         pwm_cnt_q;
    tick_t         pwm_period_ticks;
    logic [31:0]   rdata_q;
    logic [31:0]   rmux;
    logic          duty_hit;
    logic [1:0]    duty_ch;

    assign last_index = ctrl_q[`CTRL_LAST_LSB +: 4];
    // Channel number is widened before the compare, so four channels fit the limit
    assign duty_hit   = (addr[7:4] == 4'(`REG_DUTY_BASE >> 4)) && (addr[1:0] == 2'b00)
                        && ({1'b0, addr[3:2]} < 3'(NUM_CH));
    assign duty_ch    = addr[3:2];

    // Software registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_q         <= `CTRL_RST;
            strobe_delay_q <= `WORD_RST;
            strobe_dur_q   <= `WORD_RST;
            expo_delay_q   <= `WORD_RST;
            interval_len_q <= `INTERVAL_LEN_RST;
            sel_q          <= 4'h0;
        end else if (ce && wr) begin
            unique case (addr)
                `REG_CTRL:         ctrl_q         <= wdata;
                `REG_STROBE_DELAY: strobe_delay_q <= wdata;
                `REG_STROBE_DUR:   strobe_dur_q   <= wdata;
                `REG_EXPO_DELAY:   expo_delay_q   <= wdata;
                `REG_INTERVAL_LEN: interval_len_q <= wdata;
                `REG_INTERVAL_SEL: sel_q          <= wdata[3:0];
                default: ;
            endcase
        end
    end

    // Per-interval period and duty tables
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < NUM_INT; i++) begin
                period_mem[i] <= `WORD_RST;
                for (int c = 0; c < NUM_CH; c++) begin
                    duty_mem[c][i] <= `WORD_RST;
                end
            end
        end else if (ce && wr) begin
            if (addr == `REG_PWM_PERIOD) begin
                period_mem[sel_q] <= wdata;
            end
            if (duty_hit) begin
                duty_mem[duty_ch][sel_q] <= wdata;
            end
        end
    end

    // Read mux; data appears the cycle after the read strobe
    always_comb begin
        rmux = 32'h0000_0000;
        if (duty_hit) begin
            rmux = duty_mem[duty_ch][sel_q];
        end else begin
            unique case (addr)
                `REG_CTRL:         rmux = ctrl_q;
                `REG_STATUS:       rmux = {20'h0_0000, pwm_out, interval_index,
                                           1'b0, expo_wait_q, stb_active, seq_active};
                `REG_STROBE_DELAY: rmux = strobe_delay_q;
                `REG_STROBE_DUR:   rmux = strobe_dur_q;
                `REG_EXPO_DELAY:   rmux = expo_delay_q;
                `REG_INTERVAL_LEN: rmux = interval_len_q;
                `REG_INTERVAL_SEL: rmux = {28'h000_0000, sel_q};
                `REG_PWM_PERIOD:   rmux = period_mem[sel_q];
                default:           rmux = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (ce) begin
            rdata_q <= rd ? rmux : 32'h0000_0000;
        end
    end

    // Zero outside the answer cycle, so a stale word is never taken for a new one
    assign rdata = rdata_q;

    // Trigger pin synchroniser and rising edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            trig_meta_q <= 1'b0;
            trig_sync_q <= 1'b0;
            trig_prev_q <= 1'b0;
        end else if (ce) begin
            trig_meta_q <= trigger_in;
            trig_sync_q <= trig_meta_q;
            trig_prev_q <= trig_sync_q;
        end
    end

    // Only the second stage feeds the edge logic; the first may still be settling
    assign trig_edge = trig_sync_q && !trig_prev_q;

    // Sequencer: a trigger edge starts interval 0, then each interval in turn
    // Triggers that arrive during a run are ignored rather than queued
    assign interval_end   = (seq_q == SEQ_RUN) && (ilen_cnt_q == 32'h0000_0000);
    assign interval_start = ((seq_q == SEQ_IDLE) && trig_edge && ctrl_q[`CTRL_ENABLE_BIT])
                            || (interval_end && (interval_index != last_index));

    always_ff @(posedge mclk) begin
        if (rst) begin
            seq_q          <= SEQ_IDLE;
            interval_index <= 4'h0;
            ilen_cnt_q     <= 32'h0000_0000;
        end else if (ce) begin
            unique case (seq_q)
                SEQ_IDLE: begin
                    if (interval_start) begin
                        seq_q          <= SEQ_RUN;
                        interval_index <= 4'h0;
                        ilen_cnt_q     <= interval_len_q;
                    end
                end
                SEQ_RUN: begin
                    if (interval_end) begin
                        if (interval_index == last_index) begin
                            seq_q <= SEQ_IDLE;
                        end else begin
                            interval_index <= interval_index + 4'h1;
                            ilen_cnt_q     <= interval_len_q;
                        end
                    end else begin
                        ilen_cnt_q <= ilen_cnt_q - 32'h0000_0001;
                    end
                end
                default: seq_q <= SEQ_IDLE;
            endcase
        end
    end

    assign seq_active = (seq_q == SEQ_RUN);

    // Duration held inside the supported range and the on-time limit
    // A too short request is stretched, not refused: the user sees a longer pulse
    always_comb begin
        dur_eff = strobe_dur_q;
        if (dur_eff < MIN_DUR) begin
            dur_eff = MIN_DUR;
        end
        if (dur_eff > MAX_DUR) begin
            dur_eff = MAX_DUR;
        end
        if (dur_eff > MAX_ON) begin
            dur_eff = MAX_ON;
        end
    end

    // Strobe timer; a new interval restarts it, so a pulse never runs into the next interval
    always_ff @(posedge mclk) begin
        if (rst) begin
            stb_q     <= STB_IDLE;
            stb_cnt_q <= 32'h0000_0000;
        end else if (ce) begin
            if (interval_start) begin
                stb_q     <= STB_DELAY;
                stb_cnt_q <= strobe_delay_q;
            end else begin
                unique case (stb_q)
                    STB_IDLE: ;
                    STB_DELAY: begin
                        if (stb_cnt_q == 32'h0000_0000) begin
                            stb_q     <= STB_ON;
                            stb_cnt_q <= dur_eff - 32'h0000_0001;
                        end else begin
                            stb_cnt_q <= stb_cnt_q - 32'h0000_0001;
                        end
                    end
                    STB_ON: begin
                        if (stb_cnt_q == 32'h0000_0000) begin
                            stb_q <= STB_IDLE;
                        end else begin
                            stb_cnt_q <= stb_cnt_q - 32'h0000_0001;
                        end
                    end
                    default: stb_q <= STB_IDLE;
                endcase
            end
        end
    end

    assign stb_active = (stb_q == STB_ON);

    // Registered pin drive keeps the output glitch free
    always_ff @(posedge mclk) begin
        if (rst) begin
            strobe_q <= 1'b0;
        end else if (ce) begin
            strobe_q <= stb_active ^ ctrl_q[`CTRL_POL_BIT];
        end
    end

    assign strobe_out = strobe_q;

    // Exposure delay: one-cycle pulse marks start of integration
    // Like the strobe, the exposure delay restarts with every interval
    always_ff @(posedge mclk) begin
        if (rst) begin
            expo_cnt_q   <= 32'h0000_0000;
            expo_wait_q  <= 1'b0;
            expo_pulse_q <= 1'b0;
        end else if (ce) begin
            expo_pulse_q <= 1'b0;
            if (interval_start) begin
                expo_wait_q <= 1'b1;
                expo_cnt_q  <= expo_delay_q;
            end else if (expo_wait_q) begin
                if (expo_cnt_q == 32'h0000_0000) begin
                    expo_wait_q  <= 1'b0;
                    expo_pulse_q <= 1'b1;
                end else begin
                    expo_cnt_q <= expo_cnt_q - 32'h0000_0001;
                end
            end
        end
    end

    assign expose_start = expo_pulse_q;

    // Shared PWM period counter, realigned at each interval start
    assign pwm_period_ticks = period_mem[interval_index];

    always_ff @(posedge mclk) begin
        if (rst) begin
            pwm_cnt_q <= 32'h0000_0000;
        end else if (ce) begin
            if (interval_start || (pwm_cnt_q + 32'h0000_0001 >= pwm_period_ticks)) begin
                pwm_cnt_q <= 32'h0000_0000;
            end else begin
                pwm_cnt_q <= pwm_cnt_q + 32'h0000_0001;
            end
        end
    end

    // A zero period leaves every channel dark
    // All channels share one counter, so their edges stay aligned within a period
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        pwm_channel u_ch (
            .mclk    (mclk),
            .rst     (rst),
            .ce      (ce),
            .run     (seq_active && ctrl_q[`CTRL_CHEN_LSB + c]
                      && (pwm_period_ticks != 32'h0000_0000)),
            .count   (pwm_cnt_q),
            .duty    (duty_mem[c][interval_index]),
            .pwm_out (pwm_out[c])
        );
    end

endmodule

// *** tb/led_strobe_chk.sv ***
/* Port checker for the strobe and PWM controller.
   Assumes ce held high and reads of STATUS only while settled. */
`timescale 1ns/1ps
`include "led_strobe_params.svh"
module led_strobe_chk
    import led_strobe_pkg::*;
#(
    parameter int unsigned MAX_DUR_CYC = 60,
    parameter int unsigned MAX_ON_CYC  = 40
)
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic        trigger_in,
    input wire logic        strobe_out,
    input wire logic        expose_start,
    input wire logic        seq_active,
    input wire logic [3:0]  pwm_out
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_hold;
        $stable(strobe_out) [*8];
    endsequence
    property p_rdata_idle;
        (ce && !rd) |=> (rdata == 32'h0);
    endproperty
    property p_status;
        (ce && rd && addr == `REG_STATUS) |=>
            (rdata[0] == $past(seq_active) && rdata[11:8] == $past(pwm_out));
    endproperty
    property p_seq_start;
        $rose(seq_active) |-> $past(trigger_in, 3);
    endproperty
    property p_expose_pulse;
        expose_start |=> !expose_start;
    endproperty
    property p_expose_in_run;
        expose_start |-> seq_active;
    endproperty
    property p_pwm_quiet;
        (!seq_active && !$past(seq_active)) |-> (pwm_out == 4'h0);
    endproperty
    property p_strobe_quiet;
        $changed(strobe_out) |->
            (seq_active || $past(seq_active) || $past(wr, 2) || $past(wr, 3));
    endproperty
    property p_strobe_min;
        (seq_active && $changed(strobe_out)) |=> s_hold;
    endproperty
    a_rdata_idle:    assert property (p_rdata_idle) else $error("rdata not zero");
    a_status:        assert property (p_status) else $error("status wrong");
    a_seq_start:     assert property (p_seq_start) else $error("run without trigger");
    a_expose_pulse:  assert property (p_expose_pulse) else $error("long expose");
    a_expose_in_run: assert property (p_expose_in_run) else $error("stray expose");
    a_pwm_quiet:     assert property (p_pwm_quiet) else $error("pwm when idle");
    a_strobe_quiet:  assert property (p_strobe_quiet) else $error("stray strobe");
    a_strobe_min:    assert property (p_strobe_min) else $error("short strobe");
endmodule
bind led_strobe_pwm_control led_strobe_chk #(
    .MAX_DUR_CYC(MAX_DUR_CYC), .MAX_ON_CYC(MAX_ON_CYC)) u_led_strobe_chk (
    .mclk(mclk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .trigger_in(trigger_in), .strobe_out(strobe_out),
    .expose_start(expose_start), .seq_active(seq_active), .pwm_out(pwm_out));

// *** tb/led_lights.sv ***
/* LED lights on the controller outputs: measure strobe pulses and PWM on-time.
   Assumes act_low follows the polarity set in the controller. */
`timescale 1ns/1ps
module led_lights (
    input  wire logic             mclk,
    input  wire logic             clr,
    input  wire logic             act_low,
    input  wire logic             strobe_in,
    input  wire logic [3:0]       pwm_in,
    output logic      [31:0]      stb_len,
    output logic      [7:0]       stb_cnt,
    output logic      [3:0][15:0] pwm_hi
);
    logic [31:0] run_q;
    wire         lit = strobe_in ^ act_low;
    // Length is latched at the end of a pulse, so a pulse still on reads the old one
    always_ff @(posedge mclk) begin
        if (clr) begin
            run_q <= 32'h0;
            stb_cnt <= 8'h0;
        end else if (lit) begin
            run_q <= run_q + 32'h1;
        end else if (run_q != 32'h0) begin
            stb_len <= run_q;
            stb_cnt <= stb_cnt + 8'h1;
            run_q <= 32'h0;
        end
    end
    always_ff @(posedge mclk) begin
        for (int c = 0; c < 4; c++) begin
            if (clr) pwm_hi[c] <= 16'h0;
            else if (pwm_in[c]) pwm_hi[c] <= pwm_hi[c] + 16'h1;
        end
    end
endmodule

// *** tb/test_led_strobe_pwm_control.sv ***
/* Register-level bench for the strobe and PWM controller.
   Assumes the LED model in led_lights.sv and a 25 MHz mclk. */
`timescale 1ns/1ps
`include "led_strobe_params.svh"
module test_led_strobe_pwm_control import led_strobe_pkg::*;;
    localparam logic [31:0] DUTY [2][4] = '{'{32'h3, 32'h0, 32'hC, 32'h5},
                                           '{32'h7, 32'h4, 32'h0, 32'h1}};
    localparam logic [15:0] HI [4] = '{16'h64, 16'h28, 16'h64, 16'h3C};
    logic             mclk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0;
    logic             trigger_in = 1'b0, clr = 1'b0, pol = 1'b0, seq_prev = 1'b0;
    logic             stb_prev = 1'b0, strobe_out, expose_start, seq_active;
    logic [7:0]       addr = 8'h00, stb_cnt;
    logic [31:0]      wdata = 32'h0, rdata, got, stb_len;
    logic [3:0]       pwm_out;
    logic [3:0][15:0] pwm_hi;
    int               n_fail = 0, cmp_count = 0, cyc = 0, t_seq, t_exp, t_stb, seq_len;
    always #20 mclk = ~mclk;
    led_strobe_pwm_control #(.MAX_DUR_CYC(60), .MAX_ON_CYC(40)) u_led_strobe_pwm_control (
        .mclk, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .trigger_in,
        .strobe_out, .expose_start, .seq_active, .pwm_out);
    led_lights u_led_lights (.mclk, .clr, .act_low(pol), .strobe_in(strobe_out),
        .pwm_in(pwm_out), .stb_len, .stb_cnt, .pwm_hi);
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        seq_prev <= seq_active;
        stb_prev <= strobe_out ^ pol;
        if (clr) seq_len <= 0;
        else if (seq_active) seq_len <= seq_len + 1;
        if (seq_active && !seq_prev) t_seq <= cyc;
        if (expose_start) t_exp <= cyc;
        if ((strobe_out ^ pol) && !stb_prev) t_stb <= cyc;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Trigger held six cycles so the two-stage synchroniser cannot miss it
    task automatic run();
        int n;
        @(posedge mclk);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        trigger_in <= 1'b1;
        repeat (6) @(posedge mclk);
        trigger_in <= 1'b0;
        rd_reg(`REG_STATUS, got);
        chk("status_run", {24'h0, got[7:0]}, 32'h7);
        n = 0;
        while (seq_active !== 1'b0 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        repeat (4) @(posedge mclk);
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rd_reg(`REG_CTRL, got);
        chk("ctrl_rst", got, `CTRL_RST);
        rd_reg(`REG_INTERVAL_LEN, got);
        chk("len_rst", got, `INTERVAL_LEN_RST);
        wr_reg(8'h40, 32'hA5A5_A5A5);
        rd_reg(8'h40, got);
        chk("unmapped", got, 32'h0);
        wr_reg(`REG_STROBE_DELAY, 32'h2);
        wr_reg(`REG_STROBE_DUR, 32'h1E);
        wr_reg(`REG_EXPO_DELAY, 32'h4);
        wr_reg(`REG_INTERVAL_LEN, 32'h63);
        rd_reg(`REG_STROBE_DELAY, got);
        chk("delay_rb", got, 32'h2);
        for (int i = 0; i < 2; i++) begin
            wr_reg(`REG_INTERVAL_SEL, 32'(i));
            wr_reg(`REG_PWM_PERIOD, 32'hA);
            for (int c = 0; c < 4; c++) wr_reg(`REG_DUTY_BASE + 8'(4 * c), DUTY[i][c]);
        end
        rd_reg(`REG_DUTY_BASE + 8'h4, got);
        chk("duty_rb", got, DUTY[1][1]);
        wr_reg(`REG_CTRL, 32'h0000_0F11);
        run();
        chk("seq_len", 32'(seq_len), 32'hC8);
        chk("strobe_at", 32'(t_stb - t_seq), 32'h68);
        chk("expose_at", 32'(t_exp - t_seq), 32'h69);
        chk("strobe_cnt", {24'h0, stb_cnt}, 32'h2);
        chk("strobe_len", stb_len, 32'h1E);
        for (int c = 0; c < 4; c++) chk("pwm_hi", {16'h0, pwm_hi[c]}, {16'h0, HI[c]});
        wr_reg(`REG_CTRL, 32'h0000_0703);
        pol <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("idle_level", {31'h0, strobe_out}, 32'h1);
        wr_reg(`REG_STROBE_DUR, 32'h5);
        run();
        chk("dur_min", stb_len, 32'h19);
        chk("seq_len1", 32'(seq_len), 32'h64);
        chk("pwm_off", {16'h0, pwm_hi[3]}, 32'h0);
        chk("pwm_on", {16'h0, pwm_hi[0]}, 32'h1E);
        wr_reg(`REG_STROBE_DUR, 32'h64);
        run();
        chk("dur_max", stb_len, 32'h28);
        stop_test();
    end
endmodule
